// file: rtl/rsr_exec.v
// rsr_exec.v: execution of return-with-literal, rotates, subtracts and power-down
// assumes a classic wishbone master on clk_i; file registers and stack live here
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rsr_regs.vh"

module rsr_exec #(
  parameter STACK_DEPTH = 16,
  parameter STACK_AW = 4,
  parameter FILE_DEPTH = 128,
  parameter WDOG_W = 8,
  parameter PRESC_W = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  output reg sleep_o,
  output reg busy_o
);

  localparam ST_IDLE = 2'b00;
  localparam ST_RET2 = 2'b01;
  localparam ST_SLEEP = 2'b10;

  reg [1:0] state_r;
  reg [7:0] acc_r;
  reg [7:0] stat_r;
  reg [12:0] pc_r;
  reg [STACK_AW:0] sp_r;
  reg [12:0] stack_r [0:STACK_DEPTH-1];
  reg [7:0] file_r [0:FILE_DEPTH-1];
  reg [WDOG_W-1:0] watchdog_counter_r;
  reg [PRESC_W-1:0] presc_r;
  reg [6:0] faddr_r;
  reg [7:0] lit_r;

  // next values of the core state
  reg [1:0] state_nxt;
  reg [7:0] acc_nxt;
  reg [7:0] stat_nxt;
  reg [12:0] pc_nxt;
  reg [STACK_AW:0] sp_nxt;
  reg [WDOG_W-1:0] watchdog_counter_nxt;
  reg [PRESC_W-1:0] presc_nxt;
  reg [6:0] faddr_nxt;
  reg [7:0] lit_nxt;
  reg sleep_nxt;
  reg busy_nxt;
  reg [31:0] rd_nxt;
  reg [7:0] fres;
  reg fres_ok;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire insn_go = wr & (wb_adr_i == `RSR_OFF_INSN) & (state_r == ST_IDLE);
  wire [3:0] op = wb_dat_i[11:8];
  wire [7:0] lit = wb_dat_i[7:0];
  wire [6:0] fa = wb_dat_i[6:0];
  wire dest_file = wb_dat_i[7];
  wire [7:0] fval = file_r[fa];
  wire carry = stat_r[`RSR_ST_CARRY];
  wire [STACK_AW-1:0] top_idx = sp_r[STACK_AW-1:0] - {{(STACK_AW-1){1'b0}}, 1'b1};
  wire [12:0] stack_head = stack_r[top_idx];

  // subtract via 9-bit and 5-bit sums; carry bit is not-borrow
  wire [7:0] sub_a = (op == `RSR_OP_LSUB) ? lit : fval;
  wire [8:0] diff = {1'b0, sub_a} + {1'b0, ~acc_r} + 9'h001;
  wire [4:0] ndiff = {1'b0, sub_a[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
  wire [7:0] rl_res = {fval[6:0], carry};
  wire [7:0] rr_res = {carry, fval[7:1]};

  // write strobes per target; acc, stat, pc and stack are only written while idle, faddr and fdata at any time
  wire idle_wr = wr && (state_r == ST_IDLE);
  wire wr_faddr = wr && (wb_adr_i == `RSR_OFF_FADDR);
  wire wr_fdata = wr && (wb_adr_i == `RSR_OFF_FDATA);
  wire wr_acc = idle_wr && (wb_adr_i == `RSR_OFF_ACC);
  wire wr_stat = idle_wr && (wb_adr_i == `RSR_OFF_STAT);
  wire wr_pc = idle_wr && (wb_adr_i == `RSR_OFF_PC);
  wire stk_full = sp_r[STACK_AW];
  wire stk_empty = (sp_r == {(STACK_AW+1){1'b0}});
  // push only while idle, so it never meets the return pop; a full stack drops it
  wire stk_push = idle_wr && (wb_adr_i == `RSR_OFF_STACK) && !stk_full;
  wire wake_go = wr && (wb_adr_i == `RSR_OFF_CTRL) && wb_dat_i[`RSR_CTRL_WAKE];

  // flag results shared by both subtracts, and one carry-out per rotate
  wire sub_carry = diff[8];
  wire sub_nibble = ndiff[4];
  wire sub_zero = (diff[7:0] == 8'h00);
  wire rl_cout = fval[7];
  wire rr_cout = fval[0];

  assign wb_err_o = 1'b0;

  wire mapped = (wb_adr_i == `RSR_OFF_CTRL) | (wb_adr_i == `RSR_OFF_INSN) | (wb_adr_i == `RSR_OFF_ACC) |
                (wb_adr_i == `RSR_OFF_STAT) | (wb_adr_i == `RSR_OFF_PC) | (wb_adr_i == `RSR_OFF_FADDR) |
                (wb_adr_i == `RSR_OFF_FDATA) | (wb_adr_i == `RSR_OFF_STACK) | (wb_adr_i == `RSR_OFF_WDOG);

  // read mux; unmapped offsets read as zero
  always @* begin
    rd_nxt = 32'h00000000;
    case (wb_adr_i)
      `RSR_OFF_ACC: rd_nxt = {24'h000000, acc_r};
      `RSR_OFF_STAT: rd_nxt = {24'h000000, stat_r};
      `RSR_OFF_PC: rd_nxt = {19'h0, pc_r};
      `RSR_OFF_FADDR: rd_nxt = {25'h0, faddr_r};
      `RSR_OFF_FDATA: rd_nxt = {24'h000000, file_r[faddr_r]};
      `RSR_OFF_STACK: rd_nxt = {11'h0, {(8-STACK_AW-1){1'b0}}, sp_r, stack_head};
      `RSR_OFF_WDOG: rd_nxt = {{(32-WDOG_W){1'b0}}, watchdog_counter_r};
      `RSR_OFF_CTRL: rd_nxt = {30'h0, busy_o, sleep_o};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // data stands only with ack, zero otherwise
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i && mapped) begin
        wb_dat_o <= rd_nxt;
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // write-back value for dest 1; other opcodes leave the file alone
  always @* begin
    fres = fval;
    fres_ok = 1'b0;
    case (op)
      `RSR_OP_RLC: begin
        fres = rl_res;
        fres_ok = 1'b1;
      end
      `RSR_OP_RRC: begin
        fres = rr_res;
        fres_ok = 1'b1;
      end
      `RSR_OP_FSUB: begin
        fres = diff[7:0];
        fres_ok = 1'b1;
      end
      default: begin
        fres = fval;
        fres_ok = 1'b0;
      end
    endcase
  end

  // file register storage, two writers per entry; a software write wins over an instruction result
  genvar gi;
  generate
    for (gi = 0; gi < FILE_DEPTH; gi = gi + 1) begin : g_file
      wire sw_hit = wr_fdata && (faddr_r == gi);
      wire ex_hit = insn_go && dest_file && fres_ok && (fa == gi);
      always @(posedge clk_i) begin
        if (rst_i) begin
          file_r[gi] <= 8'h00;
        end else if (sw_hit) begin
          file_r[gi] <= wb_dat_i[7:0];
        end else if (ex_hit) begin
          file_r[gi] <= fres;
        end
      end
    end
  endgenerate

  // hardware stack; software push stands in for the call logic outside
  generate
    for (gi = 0; gi < STACK_DEPTH; gi = gi + 1) begin : g_stack
      always @(posedge clk_i) begin
        if (rst_i) begin
          stack_r[gi] <= 13'h0000;
        end else if (stk_push && sp_r[STACK_AW-1:0] == gi) begin
          stack_r[gi] <= wb_dat_i[12:0];
        end
      end
    end
  endgenerate

  // next-state logic; software writes first, instruction effects override
  always @* begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    stat_nxt = stat_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    watchdog_counter_nxt = watchdog_counter_r;
    presc_nxt = presc_r;
    faddr_nxt = faddr_r;
    lit_nxt = lit_r;
    sleep_nxt = sleep_o;
    busy_nxt = busy_o;
    // watchdog runs while awake; its prescaler and counter are kept here
    if (state_r != ST_SLEEP) begin
      presc_nxt = presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
      if (&presc_r) begin
        watchdog_counter_nxt = watchdog_counter_r + {{(WDOG_W-1){1'b0}}, 1'b1};
      end
    end
    if (wr_faddr) begin
      faddr_nxt = wb_dat_i[6:0];
    end
    if (wr_acc) begin
      acc_nxt = wb_dat_i[7:0];
    end
    if (wr_stat) begin
      stat_nxt = wb_dat_i[7:0];
    end
    if (wr_pc) begin
      pc_nxt = wb_dat_i[12:0];
    end
    if (stk_push) begin
      sp_nxt = sp_r + {{STACK_AW{1'b0}}, 1'b1};
    end
    case (state_r)
      ST_IDLE: begin
        if (insn_go) begin
          case (op)
            `RSR_OP_RET_LIT: begin
              lit_nxt = lit;
              busy_nxt = 1'b1;
              state_nxt = ST_RET2;
            end
            `RSR_OP_RLC: begin
              stat_nxt[`RSR_ST_CARRY] = rl_cout;
              if (!dest_file) begin
                acc_nxt = rl_res;
              end
              pc_nxt = pc_r + 13'h0001;
            end
            `RSR_OP_RRC: begin
              stat_nxt[`RSR_ST_CARRY] = rr_cout;
              if (!dest_file) begin
                acc_nxt = rr_res;
              end
              pc_nxt = pc_r + 13'h0001;
            end
            `RSR_OP_LSUB: begin
              acc_nxt = diff[7:0];
              stat_nxt[`RSR_ST_CARRY] = sub_carry;
              stat_nxt[`RSR_ST_NIBBLE] = sub_nibble;
              stat_nxt[`RSR_ST_ZERO] = sub_zero;
              pc_nxt = pc_r + 13'h0001;
            end
            `RSR_OP_FSUB: begin
              if (!dest_file) begin
                acc_nxt = diff[7:0];
              end
              stat_nxt[`RSR_ST_CARRY] = sub_carry;
              stat_nxt[`RSR_ST_NIBBLE] = sub_nibble;
              stat_nxt[`RSR_ST_ZERO] = sub_zero;
              pc_nxt = pc_r + 13'h0001;
            end
            `RSR_OP_SLEEP: begin
              stat_nxt[`RSR_ST_TOUT] = 1'b1;
              stat_nxt[`RSR_ST_PDOWN] = 1'b0;
              watchdog_counter_nxt = {WDOG_W{1'b0}};
              presc_nxt = {PRESC_W{1'b0}};
              pc_nxt = pc_r + 13'h0001;
              sleep_nxt = 1'b1;
              busy_nxt = 1'b1;
              state_nxt = ST_SLEEP;
            end
            default: begin
              pc_nxt = pc_r + 13'h0001;
            end
          endcase
        end
      end
      ST_RET2: begin
        acc_nxt = lit_r;
        pc_nxt = stack_head;
        // empty stack: pc takes the wrapped entry, pointer stays
        if (!stk_empty) begin
          sp_nxt = sp_r - {{STACK_AW{1'b0}}, 1'b1};
        end
        busy_nxt = 1'b0;
        state_nxt = ST_IDLE;
      end
      ST_SLEEP: begin
        // only a wake write leaves sleep; instructions are refused meanwhile
        if (wake_go) begin
          sleep_nxt = 1'b0;
          busy_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // one register stage for all core state
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      acc_r <= `RSR_ACC_RST;
      stat_r <= `RSR_STAT_RST;
      pc_r <= `RSR_PC_RST;
      sp_r <= {(STACK_AW+1){1'b0}};
      watchdog_counter_r <= {WDOG_W{1'b0}};
      presc_r <= {PRESC_W{1'b0}};
      faddr_r <= 7'h00;
      lit_r <= 8'h00;
      sleep_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      stat_r <= stat_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      watchdog_counter_r <= watchdog_counter_nxt;
      presc_r <= presc_nxt;
      faddr_r <= faddr_nxt;
      lit_r <= lit_nxt;
      sleep_o <= sleep_nxt;
      busy_o <= busy_nxt;
    end
  end

endmodule // rsr_exec

// file: include/rsr_regs.vh
// rsr_regs.vh: register offsets, status bit positions, opcodes and timing counts
// assumes inclusion by bare name from the execution unit
`ifndef RSR_REGS_VH
`define RSR_REGS_VH

// wishbone word offsets (byte addresses)
`define RSR_OFF_CTRL 8'h00
`define RSR_OFF_INSN 8'h04
`define RSR_OFF_ACC 8'h08
`define RSR_OFF_STAT 8'h0C
`define RSR_OFF_PC 8'h10
`define RSR_OFF_FADDR 8'h14
`define RSR_OFF_FDATA 8'h18
`define RSR_OFF_STACK 8'h1C
`define RSR_OFF_WDOG 8'h20

// status register bit positions
`define RSR_ST_CARRY 0
`define RSR_ST_NIBBLE 1
`define RSR_ST_ZERO 2
`define RSR_ST_PDOWN 3
`define RSR_ST_TOUT 4

// control bits
`define RSR_CTRL_WAKE 0
`define RSR_CTRL_STKPUSH 1

// reset values
`define RSR_STAT_RST 8'h18
`define RSR_ACC_RST 8'h00
`define RSR_PC_RST 13'h0000

// opcodes in insn[11:8]
`define RSR_OP_RET_LIT 4'h1
`define RSR_OP_RLC 4'h2
`define RSR_OP_RRC 4'h3
`define RSR_OP_LSUB 4'h4
`define RSR_OP_FSUB 4'h5
`define RSR_OP_SLEEP 4'h6

// instruction timing (cycles)
`define RSR_RET_CYCLES 2
`define RSR_ONE_CYCLE 1

`endif

// file: verif/rsr_exec_checker.sv
// rsr_exec_checker.sv: port-level assertions for the execution unit
// assumes a bind onto rsr_exec, one clock domain, sync reset
`timescale 1ns/1ps
module rsr_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire sleep_o,
  input wire busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = tk && wb_we_i && wb_sel_i[0];
  // an instruction write only counts when the unit is free
  wire ins = wr && wb_adr_i == 8'h04 && !busy_o && !sleep_o;
  wire [3:0] op = wb_dat_i[11:8];
  chk_ack_latency: assert property (tk |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  chk_err_low: assert property (!wb_err_o) else $error("err raised");
  chk_ret_two: assert property (ins && op == 4'h1 |=> busy_o ##1 !busy_o) else $error("return length");
  chk_rot_one: assert property (ins && (op == 4'h2 || op == 4'h3) |=> !busy_o) else $error("rotate busy");
  chk_sleep_enter: assert property (ins && op == 4'h6 |=> sleep_o && busy_o) else $error("no sleep");
  chk_sleep_hold: assert property (sleep_o && !(wr && wb_adr_i == 8'h00 && wb_dat_i[0]) |=> sleep_o)
    else $error("left sleep");
  chk_sleep_busy: assert property (sleep_o |-> busy_o) else $error("asleep not busy");
endmodule // rsr_chk

bind rsr_exec rsr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_o(sleep_o), .busy_o(busy_o));

// file: verif/tb.sv
// tb.sv: register-level tests of rsr_exec over classic wishbone
// assumes the checker file is compiled alongside
`timescale 1ns/1ps
module tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0;
  wire [31:0] rdat;
  wire ack;
  wire sleep;
  wire busy;
  integer err_count = 0;
  integer tests_run = 0;
  integer cyc_n = 0;
  integer i;
  reg [31:0] q;
  reg [7:0] a;
  reg [7:0] v;
  reg [7:0] r;
  logic [7:0] va [6] = '{8'h05, 8'h03, 8'h10, 8'h20, 8'h04, 8'hFF};
  logic [7:0] vv [6] = '{8'h03, 8'h03, 8'h0F, 8'h20, 8'h13, 8'h00};
  always #2 clk_i = ~clk_i;
  rsr_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(), .sleep_o(sleep), .busy_o(busy));
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ack read before this edge's updates land, so it is the sampled value
  task xfer(input [7:0] ad, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task rchk(input [7:0] ad, input [31:0] exp);
    begin
      xfer(ad, 1'b0, 32'h0);
      tests_run = tests_run + 1;
      if (q !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t addr %h got %h exp %h", $time, ad, q, exp);
      end
    end
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_count = err_count + 1;
      $display("[ERR] %0t timeout", $time);
      test_done;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(8'h0C, 32'h18);
    xfer(8'h1C, 1'b1, 32'h0123);
    xfer(8'h1C, 1'b1, 32'h0ABC);
    xfer(8'h04, 1'b1, 32'h1FF);
    rchk(8'h08, 32'hFF);
    rchk(8'h10, 32'h0ABC);
    rchk(8'h1C, 32'h2123);
    xfer(8'h04, 1'b1, 32'h100);
    rchk(8'h10, 32'h0123);
    rchk(8'h08, 32'h0);
    $display("return test done");
    xfer(8'h14, 1'b1, 32'h7F);
    xfer(8'h18, 1'b1, 32'hE6);
    xfer(8'h0C, 1'b1, 32'h1C);
    xfer(8'h04, 1'b1, 32'h27F);
    rchk(8'h08, 32'hCC);
    rchk(8'h0C, 32'h1D);
    xfer(8'h04, 1'b1, 32'h3FF);
    rchk(8'h18, 32'hF3);
    rchk(8'h0C, 32'h1C);
    $display("rotate test done");
    for (i = 0; i < 6; i = i + 1) begin
      a = va[i];
      v = vv[i];
      r = v - a;
      xfer(8'h08, 1'b1, {24'h0, a});
      xfer(8'h18, 1'b1, {24'h0, v});
      xfer(8'h04, 1'b1, i < 3 ? {20'h4, v} : {20'h5, i == 5, 7'h7F});
      rchk(i == 5 ? 8'h18 : 8'h08, {24'h0, r});
      rchk(8'h0C, {27'h0, 2'b11, r == 8'h0, a[3:0] <= v[3:0], a <= v});
    end
    $display("subtract test done");
    xfer(8'h0C, 1'b1, 32'h08);
    // give the watchdog time to move off zero
    repeat (300) @(posedge clk_i);
    xfer(8'h20, 1'b0, 32'h0);
    tests_run = tests_run + 1;
    if ((q[7:0] > 8'h00) !== 1'b1 || q[31:8] !== 24'h0) begin
      err_count = err_count + 1;
      $display("[ERR] %0t watchdog idle before power-down", $time);
    end
    xfer(8'h04, 1'b1, 32'h600);
    rchk(8'h0C, 32'h10);
    rchk(8'h20, 32'h0);
    rchk(8'h00, 32'h3);
    xfer(8'h04, 1'b1, 32'h155);
    rchk(8'h08, 32'hFF);
    rchk(8'h40, 32'h0);
    xfer(8'h00, 1'b1, 32'h1);
    rchk(8'h00, 32'h0);
    $display("sleep test done");
    test_done;
  end
endmodule // tb
